// file: inc/jtp_pkg.sv
// Package: constants and types for the test access port with OTP security
//==========================================================================
// Behaviour
// - One standard test access port with a 4-bit instruction register and a 32-bit data path.
// - Behind the port, a chained chip-level port reaches each processing tile.
// - Five test clocks with mode select high return the controller to reset.
// - The identification instruction shifts a fixed 32-bit version, part and maker value.
// - The user code carries bits 13:0 of tile 0's user word in bits 31:18, zero if blank.
// - The user identity field is loaded by firmware after reset and is invalid during reset.
// - Instruction eight shifts the data path straight into the PLL settings register.
// - Security bit 0 set denies all port access to that tile's state and memory.
// - Security bit 4 set in tile 0's word refuses port writes to the PLL configuration register; tile 1's bit 4 is not used.
// - Security bit 5 set forces the tile to boot from OTP address 0.
// - Security bit 7 set gives a unified store: 0x400-0x404 flagged inactive but still active tile 0 user words, 0x001 holds tile 1.
// - Unified user content spans words 0x005 to 0x7FF.
// - Split mode gives tile 0 words 0x005-0x3FF and tile 1 words 0x405-0x7FF.
// - Split mode reads tile 1 security from 0x401 and ignores 0x400.
package jtp_pkg;

  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int OTP_AW = 11;
  localparam int TAP_TO_RESET = 5;

  // Instruction codes; IDENTIFICATION_CODE/USERCODE/chip-chain values are arbitrary
  localparam logic [3:0] INS_EXTEST   = 4'h0;
  localparam logic [3:0] INS_IDENTIFICATION_CODE   = 4'h1;
  localparam logic [3:0] INS_USERCODE = 4'h2;
  localparam logic [3:0] INS_CHIPTAP  = 4'h3;
  localparam logic [3:0] INS_PLL      = 4'h8;
  localparam logic [3:0] INS_BYPASS   = 4'hF;

  // OTP word addresses
  localparam logic [10:0] OTP_SEC_T0     = 11'h000;
  localparam logic [10:0] OTP_SEC_T1_UNI = 11'h001;
  localparam logic [10:0] OTP_USER_WORD  = 11'h004;
  localparam logic [10:0] OTP_T0_LO      = 11'h005;
  localparam logic [10:0] OTP_T0_HI      = 11'h3FF;
  localparam logic [10:0] OTP_SPLIT_LO   = 11'h400;
  localparam logic [10:0] OTP_SEC_T1_SPL = 11'h401;
  localparam logic [10:0] OTP_SPLIT_HI   = 11'h404;
  localparam logic [10:0] OTP_T1_LO      = 11'h405;
  localparam logic [10:0] OTP_TOP        = 11'h7FF;

  // Security word fields
  localparam int SEC_NO_JTAG = 0;
  localparam int SEC_NO_PLL  = 4;
  localparam int SEC_SECBOOT = 5;
  localparam int SEC_UNIFIED = 7;

  localparam int UID_W   = 14;
  localparam int UID_LSB = 18;

  // Identity fields: arbitrary neutral values
  localparam logic [3:0]  ID_VERSION = 4'h0;
  localparam logic [15:0] ID_PART    = 16'h0001;
  localparam logic [10:0] ID_MAKER   = 11'h055;
  localparam logic [17:0] UC_REV     = 18'h00A00;

  localparam logic [31:0] PLL_RESET_VAL = 32'h0000_0000;
  localparam int PLL_RST_BIT  = 31;
  localparam int PLL_BOOT_BIT = 30;

  typedef enum logic [3:0] {
    TS_RESET  = 4'h0, TS_IDLE   = 4'h1, TS_SEL_DR = 4'h3, TS_CAP_DR = 4'h2,
    TS_SH_DR  = 4'h6, TS_EX1_DR = 4'h7, TS_PA_DR  = 4'h5, TS_EX2_DR = 4'h4,
    TS_UP_DR  = 4'hC, TS_SEL_IR = 4'hD, TS_CAP_IR = 4'hF, TS_SH_IR  = 4'hE,
    TS_EX1_IR = 4'hA, TS_PA_IR  = 4'hB, TS_EX2_IR = 4'h9, TS_UP_IR  = 4'h8
  } jtp_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtp_pins_t;

  typedef struct packed {
    logic [31:0] t0;
    logic [31:0] t1;
  } jtp_sec_t;

endpackage

// file: src/jtp_sync.sv
// Two-flop synchroniser for the debugger pins
`timescale 1ns/100ps
module jtp_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  if (W < 1) begin : g_bad_width
    $error("jtp_sync needs a positive width");
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // jtp_sync

// file: src/jtp_otp_map.sv
// OTP security decode: unified or split map
`timescale 1ns/100ps
module jtp_otp_map (
  input  wire logic              unified,
  input  wire logic [31:0]       sec_t0,
  input  wire logic [31:0]       sec_t1_uni,
  input  wire logic [31:0]       sec_t1_spl,
  input  wire logic [10:0]       addr,
  output jtp_pkg::jtp_sec_t      sec,
  output logic                   t0_user,
  output logic                   t1_user,
  output logic                   inactive
);
  // Security words per mode
  always_comb begin
    sec.t0 = sec_t0;
    sec.t1 = unified ? sec_t1_uni : sec_t1_spl;
  end

  // Region classification of a user address
  always_comb begin
    inactive = !unified && addr == jtp_pkg::OTP_SPLIT_LO;
    if (unified) begin
      inactive = addr >= jtp_pkg::OTP_SPLIT_LO &&
                 addr <= jtp_pkg::OTP_SPLIT_HI;
      // Split-mode slots hold user words here
      t0_user  = addr >= jtp_pkg::OTP_T0_LO &&
                 addr <= jtp_pkg::OTP_TOP;
      t1_user  = 1'b0;
    end else begin
      t0_user = addr >= jtp_pkg::OTP_T0_LO &&
                addr <= jtp_pkg::OTP_T0_HI;
      t1_user = addr >= jtp_pkg::OTP_T1_LO;
    end
  end
endmodule // jtp_otp_map

// file: src/jtp_tap.sv
// Test access port with OTP-driven security and PLL path
`timescale 1ns/100ps
module jtp_tap (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        TCK,
  input  wire logic        TMS,
  input  wire logic        TDI,
  input  wire logic        TRST_N,
  output logic             TDO,
  output logic             TDO_OE_N,
  input  wire logic [31:0] OTP_SEC_T0,
  input  wire logic [31:0] OTP_SEC_T1_UNI,
  input  wire logic [31:0] OTP_SEC_T1_SPL,
  input  wire logic [31:0] OTP_USER_WORD,
  input  wire logic        USER_ID_LOAD,
  input  wire logic [10:0] OTP_ADDR,
  output logic             OTP_ADDR_ACTIVE,
  output logic             OTP_ADDR_T1,
  output logic [31:0]      PLL_SETTINGS,
  output logic             CHIP_RESET_REQ,
  output logic             BOOT_FROM_TAP,
  output logic [1:0]       BOOT_OTP,
  output logic [1:0]       TILE_ACCESS_EN,
  output logic             CHIP_TDI,
  output logic             CHIP_TCK_RISE,
  output logic             CHIP_TMS,
  input  wire logic        CHIP_TDO
);
  //==========================================================================
  // Pin sampling
  jtp_pkg::jtp_pins_t pins_raw, pins;
  assign pins_raw = '{tck: TCK, tms: TMS, tdi: TDI, trst_n: TRST_N};

  jtp_sync #(.W(4)) u_sync (
    .clk (CORE_CLK),
    .rst (RESET),
    .d   (pins_raw),
    .q   (pins)
  );

  logic tck_d_r;
  logic tck_rise;
  logic tck_fall;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) tck_d_r <= 1'b0;
    else tck_d_r <= pins.tck;
  end
  assign tck_rise = pins.tck & ~tck_d_r;
  assign tck_fall = ~pins.tck & tck_d_r;

  //==========================================================================
  // Security decode
  jtp_pkg::jtp_sec_t sec;
  logic unified;
  logic t0_user;
  logic t1_user;
  logic inactive;
  assign unified = OTP_SEC_T0[jtp_pkg::SEC_UNIFIED];

  jtp_otp_map u_map (
    .unified    (unified),
    .sec_t0     (OTP_SEC_T0),
    .sec_t1_uni (OTP_SEC_T1_UNI),
    .sec_t1_spl (OTP_SEC_T1_SPL),
    .addr       (OTP_ADDR),
    .sec        (sec),
    .t0_user    (t0_user),
    .t1_user    (t1_user),
    .inactive   (inactive)
  );
  assign OTP_ADDR_ACTIVE = t0_user | t1_user;
  assign OTP_ADDR_T1     = t1_user;

  logic pll_locked;
  assign pll_locked = sec.t0[jtp_pkg::SEC_NO_PLL];
  always_comb begin
    TILE_ACCESS_EN[0] = ~sec.t0[jtp_pkg::SEC_NO_JTAG];
    TILE_ACCESS_EN[1] = ~sec.t1[jtp_pkg::SEC_NO_JTAG];
    BOOT_OTP[0] = sec.t0[jtp_pkg::SEC_SECBOOT];
    BOOT_OTP[1] = sec.t1[jtp_pkg::SEC_SECBOOT];
  end

  //==========================================================================
  // Controller
  jtp_pkg::jtp_state_t st_r, st_nxt;
  logic [2:0] tms_hi_r;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      jtp_pkg::TS_RESET:  st_nxt = pins.tms ? jtp_pkg::TS_RESET
                                            : jtp_pkg::TS_IDLE;
      jtp_pkg::TS_IDLE:   st_nxt = pins.tms ? jtp_pkg::TS_SEL_DR
                                            : jtp_pkg::TS_IDLE;
      jtp_pkg::TS_SEL_DR: st_nxt = pins.tms ? jtp_pkg::TS_SEL_IR
                                            : jtp_pkg::TS_CAP_DR;
      jtp_pkg::TS_CAP_DR: st_nxt = pins.tms ? jtp_pkg::TS_EX1_DR
                                            : jtp_pkg::TS_SH_DR;
      jtp_pkg::TS_SH_DR:  st_nxt = pins.tms ? jtp_pkg::TS_EX1_DR
                                            : jtp_pkg::TS_SH_DR;
      jtp_pkg::TS_EX1_DR: st_nxt = pins.tms ? jtp_pkg::TS_UP_DR
                                            : jtp_pkg::TS_PA_DR;
      jtp_pkg::TS_PA_DR:  st_nxt = pins.tms ? jtp_pkg::TS_EX2_DR
                                            : jtp_pkg::TS_PA_DR;
      jtp_pkg::TS_EX2_DR: st_nxt = pins.tms ? jtp_pkg::TS_UP_DR
                                            : jtp_pkg::TS_SH_DR;
      jtp_pkg::TS_UP_DR:  st_nxt = pins.tms ? jtp_pkg::TS_SEL_DR
                                            : jtp_pkg::TS_IDLE;
      jtp_pkg::TS_SEL_IR: st_nxt = pins.tms ? jtp_pkg::TS_RESET
                                            : jtp_pkg::TS_CAP_IR;
      jtp_pkg::TS_CAP_IR: st_nxt = pins.tms ? jtp_pkg::TS_EX1_IR
                                            : jtp_pkg::TS_SH_IR;
      jtp_pkg::TS_SH_IR:  st_nxt = pins.tms ? jtp_pkg::TS_EX1_IR
                                            : jtp_pkg::TS_SH_IR;
      jtp_pkg::TS_EX1_IR: st_nxt = pins.tms ? jtp_pkg::TS_UP_IR
                                            : jtp_pkg::TS_PA_IR;
      jtp_pkg::TS_PA_IR:  st_nxt = pins.tms ? jtp_pkg::TS_EX2_IR
                                            : jtp_pkg::TS_PA_IR;
      jtp_pkg::TS_EX2_IR: st_nxt = pins.tms ? jtp_pkg::TS_UP_IR
                                            : jtp_pkg::TS_SH_IR;
      jtp_pkg::TS_UP_IR:  st_nxt = pins.tms ? jtp_pkg::TS_SEL_DR
                                            : jtp_pkg::TS_IDLE;
    endcase
    // Redundant guard: five high TMS edges force reset from any state
    if (pins.tms && tms_hi_r == 3'(jtp_pkg::TAP_TO_RESET - 1))
      st_nxt = jtp_pkg::TS_RESET;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || !pins.trst_n) begin
      st_r     <= jtp_pkg::TS_RESET;
      tms_hi_r <= 3'h0;
    end else if (tck_rise) begin
      st_r <= st_nxt;
      if (!pins.tms) tms_hi_r <= 3'h0;
      else if (tms_hi_r != 3'(jtp_pkg::TAP_TO_RESET - 1))
        tms_hi_r <= tms_hi_r + 3'h1;
    end
  end

  //==========================================================================
  // Instruction and data shift paths
  logic [3:0]  ir_sh_r;
  logic [3:0]  ir_r;
  logic [31:0] dr_r;
  logic [13:0] uid_r;
  logic        dr_single;

  // Only the identification, user code, PLL and chip-chain codes use the 32-bit path
  assign dr_single = !(ir_r inside {jtp_pkg::INS_IDENTIFICATION_CODE, jtp_pkg::INS_USERCODE,
                                    jtp_pkg::INS_PLL, jtp_pkg::INS_CHIPTAP});

  always_ff @(posedge CORE_CLK) begin
    if (RESET) uid_r <= '0;
    else if (USER_ID_LOAD) uid_r <= OTP_USER_WORD[13:0];
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || !pins.trst_n) begin
      ir_sh_r <= 4'h0;
      ir_r    <= jtp_pkg::INS_IDENTIFICATION_CODE;
    end else if (tck_rise) begin
      unique case (st_r)
        jtp_pkg::TS_RESET:  ir_r    <= jtp_pkg::INS_IDENTIFICATION_CODE;
        jtp_pkg::TS_CAP_IR: ir_sh_r <= 4'h1;
        jtp_pkg::TS_SH_IR:  ir_sh_r <= {pins.tdi, ir_sh_r[3:1]};
        jtp_pkg::TS_UP_IR:  ir_r    <= ir_sh_r;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      dr_r <= '0;
    end else if (tck_rise) begin
      if (st_r == jtp_pkg::TS_CAP_DR) begin
        unique case (ir_r)
          jtp_pkg::INS_IDENTIFICATION_CODE:
            dr_r <= {jtp_pkg::ID_VERSION, jtp_pkg::ID_PART,
                     jtp_pkg::ID_MAKER, 1'b1};
          jtp_pkg::INS_USERCODE:
            dr_r <= {uid_r, jtp_pkg::UC_REV};
          jtp_pkg::INS_PLL: dr_r <= PLL_SETTINGS;
          default: dr_r <= '0;
        endcase
      end else if (st_r == jtp_pkg::TS_SH_DR) begin
        if (dr_single) dr_r <= {31'h0, pins.tdi};
        else dr_r <= {pins.tdi, dr_r[31:1]};
      end
    end
  end

  //==========================================================================
  // PLL settings write
  logic pll_wr;
  assign pll_wr = tck_rise && st_r == jtp_pkg::TS_UP_DR &&
                  ir_r == jtp_pkg::INS_PLL && !pll_locked;

  // Written on the TCK rise that leaves Update-DR, so a TCK stopped in Update-DR holds the write back until the next rise
  always_ff @(posedge CORE_CLK) begin
    if (RESET) PLL_SETTINGS <= jtp_pkg::PLL_RESET_VAL;
    else if (pll_wr) PLL_SETTINGS <= dr_r;
  end
  assign CHIP_RESET_REQ = PLL_SETTINGS[jtp_pkg::PLL_RST_BIT];
  assign BOOT_FROM_TAP  = PLL_SETTINGS[jtp_pkg::PLL_BOOT_BIT];

  //==========================================================================
  // Chip-level chain and TDO
  logic chip_sel;
  logic shifting;
  assign chip_sel = ir_r == jtp_pkg::INS_CHIPTAP && (|TILE_ACCESS_EN);
  assign shifting = st_r == jtp_pkg::TS_SH_DR || st_r == jtp_pkg::TS_SH_IR;
  assign CHIP_TDI      = chip_sel ? pins.tdi : 1'b0;
  assign CHIP_TMS      = chip_sel ? pins.tms : 1'b1;
  assign CHIP_TCK_RISE = chip_sel & tck_rise;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      TDO      <= 1'b0;
      TDO_OE_N <= 1'b1;
    end else if (tck_fall) begin
      TDO_OE_N <= ~shifting;
      if (st_r == jtp_pkg::TS_SH_IR) TDO <= ir_sh_r[0];
      else if (chip_sel) TDO <= CHIP_TDO;
      else TDO <= dr_r[0];
    end
  end
endmodule // jtp_tap

// file: test/jtp_tap_sva.sv
// Checker for the test access port top level
`timescale 1ns/100ps
module jtp_tap_sva (
  input logic        CORE_CLK,
  input logic        RESET,
  input logic        TCK,
  input logic        TDO,
  input logic        TDO_OE_N,
  input logic [31:0] OTP_SEC_T0,
  input logic [31:0] OTP_SEC_T1_UNI,
  input logic [31:0] OTP_SEC_T1_SPL,
  input logic [10:0] OTP_ADDR,
  input logic        OTP_ADDR_ACTIVE,
  input logic        OTP_ADDR_T1,
  input logic [31:0] PLL_SETTINGS,
  input logic        CHIP_RESET_REQ,
  input logic        BOOT_FROM_TAP,
  input logic [1:0]  BOOT_OTP,
  input logic [1:0]  TILE_ACCESS_EN,
  input logic        CHIP_TCK_RISE,
  input logic        CHIP_TDI,
  input logic        CHIP_TMS
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic        uni;
  logic [31:0] t1;
  logic        act;
  // Tile 1 word moves with the map mode
  assign uni = OTP_SEC_T0[7];
  assign t1  = uni ? OTP_SEC_T1_UNI : OTP_SEC_T1_SPL;
  assign act = uni ? (OTP_ADDR >= 11'h005) : (OTP_ADDR >= 11'h405 ||
               (OTP_ADDR >= 11'h005 && OTP_ADDR <= 11'h3FF));
  chk_reset_clear: assert property ($fell(RESET) |->
    PLL_SETTINGS == 32'h0 && TDO_OE_N && !TDO) else $error("reset state");
  chk_pll_bits: assert property (CHIP_RESET_REQ == PLL_SETTINGS[31] &&
    BOOT_FROM_TAP == PLL_SETTINGS[30]) else $error("pll bit outputs");
  chk_pll_lock: assert property (OTP_SEC_T0[4] && $past(OTP_SEC_T0[4])
    |=> $stable(PLL_SETTINGS)) else $error("locked pll written");
  chk_tile_deny: assert property (TILE_ACCESS_EN ==
    ~{t1[0], OTP_SEC_T0[0]}) else $error("tile access enable");
  chk_boot_otp: assert property (BOOT_OTP == {t1[5], OTP_SEC_T0[5]})
    else $error("secure boot select");
  chk_addr_map: assert property (OTP_ADDR_ACTIVE == act &&
    OTP_ADDR_T1 == (!uni && OTP_ADDR >= 11'h405)) else $error("otp map");
  chk_tdo_fall: assert property ($changed(TDO) |->
    !$past(TCK) && !$past(TCK, 2)) else $error("tdo moved off fall");
  chk_chip_pulse: assert property (CHIP_TCK_RISE |=> !CHIP_TCK_RISE)
    else $error("chip clock pulse long");
  chk_chip_gate: assert property (CHIP_TCK_RISE |->
    TILE_ACCESS_EN != 2'b00) else $error("chip chain while denied");
  chk_chip_park: assert property (TILE_ACCESS_EN == 2'b00 |->
    CHIP_TMS && !CHIP_TDI) else $error("chip chain not parked");
  chk_oe_fall: assert property ($changed(TDO_OE_N) |->
    !$past(TCK) && !$past(TCK, 2)) else $error("tdo enable off fall");
endmodule // jtp_tap_sva

bind jtp_tap jtp_tap_sva i_sva (.CORE_CLK, .RESET, .TCK, .TDO, .TDO_OE_N,
  .OTP_SEC_T0, .OTP_SEC_T1_UNI, .OTP_SEC_T1_SPL, .OTP_ADDR, .OTP_ADDR_ACTIVE,
  .OTP_ADDR_T1, .PLL_SETTINGS, .CHIP_RESET_REQ, .BOOT_FROM_TAP, .BOOT_OTP,
  .TILE_ACCESS_EN, .CHIP_TCK_RISE, .CHIP_TDI, .CHIP_TMS);

// file: test/jtp_dbg.sv
// Debugger model driving the test port pins
`timescale 1ns/100ps
module jtp_dbg (
  output logic TCK,
  output logic TMS,
  output logic TDI,
  input  logic TDO
);
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b1;
  end
  //==========================================================
  // Pin cycles; clock parks low between frames
  task automatic tick(input logic ms, input logic di, output logic d);
    TMS = ms;
    TDI = di;
    #62.5;
    d = TDO;
    TCK = 1'b1;
    #62.5;
    TCK = 1'b0;
  endtask
  task automatic moves(input logic [7:0] seq, input int n);
    logic d;
    for (int i = 0; i < n; i++)
      tick(seq[i], 1'b0, d);
  endtask
  // LSB first, last bit leaves shift, then Update and Idle
  task automatic shift(input logic [31:0] v, input int n,
                       output logic [31:0] q);
    q = 32'h0;
    for (int i = 0; i < n; i++)
      tick(i == n - 1, v[i], q[i]);
    moves(8'h01, 2);
  endtask
  task automatic ir(input logic [3:0] code);
    logic [31:0] q;
    moves(8'h03, 4);
    shift({28'h0, code}, 4, q);
  endtask
  task automatic dr(input logic [31:0] v, output logic [31:0] q);
    moves(8'h01, 3);
    shift(v, 32, q);
  endtask
  task automatic tap_reset();
    moves(8'h1F, 5);
    moves(8'h00, 1);
  endtask
  task automatic pll_write(input logic [31:0] v);
    logic [31:0] q;
    ir(jtp_pkg::INS_PLL);
    dr(v, q);
    // Clock is not free running, so settle the write
    moves(8'h00, 100);
  endtask
endmodule // jtp_dbg

// file: test/testbench.sv
// Self-checking bench for the test access port
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tck, tms, tdi, tdo, uid_load, tck_rise;
  logic [31:0] sec_t0, sec_uni, sec_spl, uword, pll, v, w, got_q;
  logic [10:0] addr;
  logic [1:0]  boot_otp, tile_en;
  logic        act, addr_act, addr_t1, rst_req, boot_tap;
  logic [31:0] exp_q[$];
  logic [3:0]  byp[12] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9,
                           4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  logic [10:0] addrs[10] = '{11'h000, 11'h001, 11'h004, 11'h005, 11'h3FF,
                             11'h400, 11'h401, 11'h404, 11'h405, 11'h7FF};
  int          num_errors = 0;
  int          total_checks = 0;
  int          seed = 32'h707E0E86;
  event        got;
  localparam logic [31:0] ID_EXP = {jtp_pkg::ID_VERSION, jtp_pkg::ID_PART,
                                    jtp_pkg::ID_MAKER, 1'b1};
  always #4 clk = ~clk;
  jtp_dbg i_dbg (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo));
  jtp_tap i_dut (.CORE_CLK(clk), .RESET(rst), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TRST_N(1'b1), .TDO(tdo), .TDO_OE_N(), .OTP_SEC_T0(sec_t0),
    .OTP_SEC_T1_UNI(sec_uni), .OTP_SEC_T1_SPL(sec_spl),
    .OTP_USER_WORD(uword), .USER_ID_LOAD(uid_load), .OTP_ADDR(addr),
    .OTP_ADDR_ACTIVE(addr_act), .OTP_ADDR_T1(addr_t1), .PLL_SETTINGS(pll),
    .CHIP_RESET_REQ(rst_req), .BOOT_FROM_TAP(boot_tap), .BOOT_OTP(boot_otp),
    .TILE_ACCESS_EN(tile_en), .CHIP_TDI(), .CHIP_TCK_RISE(tck_rise),
    .CHIP_TMS(), .CHIP_TDO(tdi));
  //==========================================================
  // Checking helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic sdr(input logic [31:0] e);
    exp_q.push_back(e);
    i_dbg.dr(v, got_q);
    -> got;
  endtask
  task automatic scan(input logic [3:0] code, input logic [31:0] e);
    i_dbg.ir(code);
    sdr(e);
  endtask
  initial forever begin
    @(got);
    chk(got_q, exp_q.pop_front());
  end
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  //==========================================================
  // Main sequence
  initial begin
    {uid_load, sec_t0, sec_uni, sec_spl, uword, addr} = '0;
    v = 32'h0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    i_dbg.moves(8'h00, 1);
    sdr(ID_EXP);
    scan(jtp_pkg::INS_USERCODE, {14'h0, jtp_pkg::UC_REV});
    i_dbg.tap_reset();
    sdr(ID_EXP);
    foreach (byp[k]) begin
      v = $random(seed);
      scan(byp[k], {v[30:0], 1'b0});
    end
    @(negedge clk);
    uword = $random(seed);
    uid_load = 1'b1;
    @(negedge clk);
    uid_load = 1'b0;
    scan(jtp_pkg::INS_USERCODE, {uword[13:0], jtp_pkg::UC_REV});
    v = $random(seed);
    i_dbg.pll_write(v);
    chk(pll, v);
    chk({30'h0, rst_req, boot_tap}, {30'h0, v[31:30]});
    sec_t0[4] = 1'b1;
    i_dbg.pll_write(~v);
    chk(pll, v);
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      {sec_t0, sec_uni, sec_spl} = {$random(seed), $random(seed), $random(seed)};
      sec_t0[7] = k[0];
      addr = addrs[k];
      #1;
      w = sec_t0[7] ? sec_uni : sec_spl;
      act = sec_t0[7] ? (addr >= 11'h005) : (addr >= 11'h405 ||
            (addr >= 11'h005 && addr <= 11'h3FF));
      chk({30'h0, tile_en}, {30'h0, ~w[0], ~sec_t0[0]});
      chk({30'h0, boot_otp}, {30'h0, w[5], sec_t0[5]});
      chk({31'h0, addr_act}, {31'h0, act});
      chk({31'h0, addr_t1}, {31'h0, !sec_t0[7] && addr >= 11'h405});
    end
    for (int k = 0; k < 2; k++) begin
      sec_t0 = {31'h0, k[0]};
      sec_spl = {31'h0, k[0]};
      v = $random(seed);
      // Chip side loops TDI back; denied tiles leave the zero capture
      w = k[0] ? 32'h0 : v;
      scan(jtp_pkg::INS_CHIPTAP, w);
    end
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(pll, 32'h0);
    i_dbg.moves(8'h00, 1);
    scan(jtp_pkg::INS_USERCODE, {14'h0, jtp_pkg::UC_REV});
    repeat (4) @(negedge clk);
    finish_test();
  end
endmodule // testbench
